// ==== pmc_map.vh ====
`ifndef PMC_MAP_VH
`define PMC_MAP_VH

// register offsets on the plain register port
`define PMC_ADDR_CTRL      8'h00
`define PMC_ADDR_STAT      8'h01

// power_mode_control_reg layout and reset value
`define PMC_CTRL_RESET     8'h40
`define PMC_BIT_SLOW_ON    7
`define PMC_BIT_FAST_ON    6
`define PMC_BIT_IDLE_SLOW  5
`define PMC_BIT_CORE_SLOW  4
`define PMC_BIT_RSVD       3
`define PMC_SEL_MSB        2

// valid upper-nibble codes {slow_on, fast_on, idle_slow, core_slow}
`define PMC_NIB_HS         4'h4
`define PMC_NIB_HS_DC      4'hc
`define PMC_NIB_DC         4'he
`define PMC_NIB_DC_LS      4'hf
`define PMC_NIB_LS         4'hb

// operating modes as reported in status
`define PMC_MODE_HS        2'h0
`define PMC_MODE_DC        2'h1
`define PMC_MODE_LS        2'h2

// status register bit positions
`define PMC_STAT_PEND      0
`define PMC_STAT_IRST      1

// instruction cycle is five fast-oscillator periods
`define PMC_TC_DIV_LAST    3'h4

// idle timer taps: code 0 watches bit 12 (4k), code 4 bit 16 (64k)
`define PMC_TAP_BASE       12
`define PMC_TAP_MAX        3'h4
`define PMC_TIMER_W        17

// idle timer presets: internal reset 00Fx, halt wake-up 256
`define PMC_IRST_UPPER     13'h000f
`define PMC_WAKE_PRESET    17'h00100
`define PMC_TIMER_ZERO     17'h00000
`define PMC_TIMER_ONE      17'h00001

`endif

// ==== pmc_clock_switch.v ====
`timescale 1ns/100ps
module pmc_clock_switch (
   input  wire clock_in,
   input  wire rst_in,
   input  wire fast_lvl_in,
   input  wire slow_lvl_in,
   input  wire sel_slow_in,
   input  wire run_in,
   output wire clock_out,
   output wire sel_slow_out
);

   reg cur_slow_q;
   reg gate_q;
   reg clk_q;
   wire cur_lvl;

   assign cur_lvl      = cur_slow_q ? slow_lvl_in : fast_lvl_in;
   assign clock_out    = clk_q;
   assign sel_slow_out = cur_slow_q;

   always @(posedge clock_in) begin
      if (rst_in) begin
         cur_slow_q <= 1'b0;
         gate_q     <= 1'b0;
         clk_q      <= 1'b0;
      end else begin
         // swap source only while both sources sit low
         if ((sel_slow_in != cur_slow_q) && !fast_lvl_in && !slow_lvl_in) begin
            cur_slow_q <= sel_slow_in;
         end
         // gate changes only in a low phase so no pulse is cut short
         if (!cur_lvl) begin
            gate_q <= run_in;
         end
         clk_q <= gate_q & cur_lvl;
      end
   end

endmodule // pmc_clock_switch

// ==== pmc_top.v ====
// Behaviour
// - three operating modes, each with halt and idle
// - halt allowed only by option input
// - idle keeps oscillator and timer; halt stops all
// - power save freezes the core; idle timer runs in idle, not in halt
// - reset loads control register with hex 40
// - bit 7 switches slow oscillator
// - bit 6 switches fast oscillator
// - bit 5 selects idle timer clock
// - bit 4 selects core clock source
// - idle fast with core slow forces low speed
// - five valid upper-nibble codes only
// - invalid upper nibble causes internal reset
// - internal reset lasts 240 to 255 cycles
// - low three bits select idle tap
// - five idle windows 4k to 64k
// - reset selects the 4096-cycle tap
// - high speed after reset, never from low
`timescale 1ns/100ps
`include "pmc_map.vh"
module pmc_top (
   input  wire       clock_in,
   input  wire       rst_in,
   input  wire [7:0] reg_addr_in,
   input  wire [7:0] reg_wdata_in,
   input  wire       reg_wr_in,
   input  wire       reg_rd_in,
   output wire [7:0] reg_rdata_out,
   input  wire       fast_osc_in,
   input  wire       slow_osc_in,
   input  wire       wakeup_in,
   input  wire       halt_option_in,
   input  wire       halt_req_in,
   input  wire       idle_req_in,
   output wire       core_clock_out,
   output wire       core_active_out,
   output wire       fast_osc_en_out,
   output wire       slow_osc_en_out,
   output wire       idle_timer_slow_out,
   output wire [1:0] mode_out,
   output wire       internal_reset_out,
   output wire       idle_timer_pend_out
);

   localparam ST_RUN   = 3'h0;
   localparam ST_IDLE  = 3'h1;
   localparam ST_HALT  = 3'h2;
   localparam ST_START = 3'h3;
   localparam ST_IRST  = 3'h4;

   // 0 fast osc, 1 slow osc, 2 wake-up pin
   reg  [2:0] meta_q;
   reg  [2:0] sync_q;
   reg  [2:0] prev_q;

   reg  [7:0]  ctrl_q;
   reg  [2:0]  state_q;
   reg  [2:0]  state_d;
   reg  [16:0] timer_q;
   reg  [16:0] timer_d;
   reg  [2:0]  presc_q;
   reg         pend_q;
   reg         irst_seen_q;
   reg  [7:0]  rdata_q;
   reg         fast_en_q;
   reg         slow_en_q;
   reg         idle_slow_q;
   reg         active_q;
   reg         irst_q;
   reg  [1:0]  mode_q;

   wire        fast_rise;
   wire        slow_rise;
   wire        wake_rise;
   wire        tc_fast;
   wire        timer_tick;
   wire        tap_event;
   wire        ctrl_wr;
   wire        stat_wr;
   wire        nib_bad;
   wire        ls_to_hs;
   wire [3:0]  nib_new;
   wire [3:0]  nib_cur;
   wire [1:0]  mode_now;
   wire        idle_slow_eff;
   wire        core_slow_eff;
   wire        core_slow_now;
   wire [7:0]  status;

   // only the five documented codes pass
   function nib_legal;
      input [3:0] nib;
      begin
         nib_legal = (nib == `PMC_NIB_HS) || (nib == `PMC_NIB_HS_DC) || (nib == `PMC_NIB_DC) ||
                     (nib == `PMC_NIB_DC_LS) || (nib == `PMC_NIB_LS);
      end
   endfunction

   // bit of the idle timer watched by the interval select
   function tap_bit;
      input [2:0]  sel;
      input [16:0] value;
      reg   [2:0]  idx;
      begin
         idx = (sel > `PMC_TAP_MAX) ? `PMC_TAP_MAX : sel;
         tap_bit = value[`PMC_TAP_BASE + idx];
      end
   endfunction

   // mode decode from idle-timer and core selects
   function [1:0] mode_of;
      input idle_slow;
      input core_slow;
      begin
         if (core_slow) begin
            mode_of = `PMC_MODE_LS;
         end else if (idle_slow) begin
            mode_of = `PMC_MODE_DC;
         end else begin
            mode_of = `PMC_MODE_HS;
         end
      end
   endfunction

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
         always @(posedge clock_in) begin
            if (rst_in) begin
               meta_q[gi] <= 1'b0;
               sync_q[gi] <= 1'b0;
               prev_q[gi] <= 1'b0;
            end else begin
               meta_q[gi] <= (gi == 0) ? fast_osc_in : ((gi == 1) ? slow_osc_in : wakeup_in);
               sync_q[gi] <= meta_q[gi];
               prev_q[gi] <= sync_q[gi];
            end
         end
      end
   endgenerate

   assign fast_rise = sync_q[0] & ~prev_q[0] & ctrl_q[`PMC_BIT_FAST_ON];
   assign slow_rise = sync_q[1] & ~prev_q[1] & ctrl_q[`PMC_BIT_SLOW_ON];
   assign wake_rise = sync_q[2] & ~prev_q[2];
   assign tc_fast   = fast_rise && (presc_q == `PMC_TC_DIV_LAST);

   assign nib_cur       = ctrl_q[7:4];
   assign nib_new       = reg_wdata_in[7:4];
   assign idle_slow_eff = ctrl_q[`PMC_BIT_IDLE_SLOW] | ctrl_q[`PMC_BIT_CORE_SLOW];
   assign core_slow_eff = ctrl_q[`PMC_BIT_CORE_SLOW];
   assign mode_now      = mode_of(ctrl_q[`PMC_BIT_IDLE_SLOW], ctrl_q[`PMC_BIT_CORE_SLOW]);

   // internal reset counts instruction cycles of the fast clock, whatever the oscillator type
   assign timer_tick = (state_q == ST_HALT) ? 1'b0 :
                       (state_q == ST_IRST) ? tc_fast :
                       (idle_slow_eff ? slow_rise : tc_fast);
   assign tap_event  = timer_tick && (state_q != ST_IRST) && (state_q != ST_START) &&
                       (tap_bit(ctrl_q[`PMC_SEL_MSB:0], timer_q) !=
                        tap_bit(ctrl_q[`PMC_SEL_MSB:0], timer_q - `PMC_TIMER_ONE));

   assign ctrl_wr  = reg_wr_in && (reg_addr_in == `PMC_ADDR_CTRL) && (state_q != ST_IRST);
   assign stat_wr  = reg_wr_in && (reg_addr_in == `PMC_ADDR_STAT);
   assign nib_bad  = ctrl_wr && !nib_legal(nib_new);
   // low speed may not jump straight to high speed
   assign ls_to_hs = (nib_cur == `PMC_NIB_LS) && (nib_new == `PMC_NIB_HS);

   assign status = {core_slow_now, state_q, mode_q, irst_seen_q, pend_q};

   // power-save and internal-reset sequencing
   always @* begin
      state_d = state_q;
      timer_d = timer_tick ? (timer_q - `PMC_TIMER_ONE) : timer_q;
      case (state_q)
         ST_RUN: begin
            if (halt_req_in && halt_option_in) begin
               state_d = ST_HALT;
            end else if (idle_req_in) begin
               state_d = ST_IDLE;
            end
         end
         ST_IDLE: begin
            if (tap_event || wake_rise) begin
               state_d = ST_RUN;
            end
         end
         ST_HALT: begin
            if (wake_rise) begin
               state_d = ST_START;
               timer_d = `PMC_WAKE_PRESET;
            end
         end
         ST_START: begin
            if (timer_tick && (timer_q == `PMC_TIMER_ONE)) begin
               state_d = ST_RUN;
            end
         end
         ST_IRST: begin
            if (timer_tick && (timer_q[15:0] == `PMC_TIMER_ONE)) begin
               state_d = ST_RUN;
            end
         end
         default: begin
            state_d = ST_RUN;
         end
      endcase
      // an illegal nibble overrides any other move
      if (nib_bad) begin
         state_d = ST_IRST;
         timer_d = {`PMC_IRST_UPPER, timer_q[3:0]};
      end
   end

   always @(posedge clock_in) begin
      if (rst_in) begin
         ctrl_q  <= `PMC_CTRL_RESET;
         state_q <= ST_RUN;
         timer_q <= `PMC_TIMER_ZERO;
         presc_q <= 3'h0;
      end else begin
         state_q <= state_d;
         timer_q <= timer_d;
         if (fast_rise) begin
            presc_q <= (presc_q == `PMC_TC_DIV_LAST) ? 3'h0 : (presc_q + 3'h1);
         end
         if (nib_bad) begin
            ctrl_q <= `PMC_CTRL_RESET;
         end else if (ctrl_wr) begin
            // reserved bit is forced to zero; a refused nibble keeps the old mode bits
            ctrl_q[7:4] <= ls_to_hs ? nib_cur : nib_new;
            ctrl_q[`PMC_BIT_RSVD] <= 1'b0;
            ctrl_q[`PMC_SEL_MSB:0] <= reg_wdata_in[`PMC_SEL_MSB:0];
         end
      end
   end

   // sticky status: a new event beats a clear in the same cycle
   always @(posedge clock_in) begin
      if (rst_in) begin
         pend_q      <= 1'b0;
         irst_seen_q <= 1'b0;
      end else begin
         if (tap_event) begin
            pend_q <= 1'b1;
         end else if (stat_wr && reg_wdata_in[`PMC_STAT_PEND]) begin
            pend_q <= 1'b0;
         end
         if (nib_bad) begin
            irst_seen_q <= 1'b1;
         end else if (stat_wr && reg_wdata_in[`PMC_STAT_IRST]) begin
            irst_seen_q <= 1'b0;
         end
      end
   end

   // read data stand one cycle, zero otherwise and for unmapped addresses
   always @(posedge clock_in) begin
      if (rst_in) begin
         rdata_q <= 8'h00;
      end else if (reg_rd_in && (reg_addr_in == `PMC_ADDR_CTRL)) begin
         rdata_q <= ctrl_q;
      end else if (reg_rd_in && (reg_addr_in == `PMC_ADDR_STAT)) begin
         rdata_q <= status;
      end else begin
         rdata_q <= 8'h00;
      end
   end

   // registered outputs; halt drops both oscillators, idle keeps them
   always @(posedge clock_in) begin
      if (rst_in) begin
         fast_en_q   <= 1'b1;
         slow_en_q   <= 1'b0;
         idle_slow_q <= 1'b0;
         active_q    <= 1'b0;
         irst_q      <= 1'b0;
         mode_q      <= `PMC_MODE_HS;
      end else begin
         fast_en_q   <= ctrl_q[`PMC_BIT_FAST_ON] && (state_q != ST_HALT);
         slow_en_q   <= ctrl_q[`PMC_BIT_SLOW_ON] && (state_q != ST_HALT);
         idle_slow_q <= idle_slow_eff;
         // core clock is held off in every power-save state so core state is frozen
         active_q    <= (state_d == ST_RUN);
         irst_q      <= (state_d == ST_IRST);
         mode_q      <= mode_now;
      end
   end

   pmc_clock_switch u_switch (
      .clock_in     (clock_in),
      .rst_in       (rst_in),
      .fast_lvl_in  (sync_q[0] & ctrl_q[`PMC_BIT_FAST_ON]),
      .slow_lvl_in  (sync_q[1] & ctrl_q[`PMC_BIT_SLOW_ON]),
      .sel_slow_in  (core_slow_eff),
      .run_in       (active_q),
      .clock_out    (core_clock_out),
      .sel_slow_out (core_slow_now)
   );

   assign reg_rdata_out       = rdata_q;
   assign core_active_out     = active_q;
   assign fast_osc_en_out     = fast_en_q;
   assign slow_osc_en_out     = slow_en_q;
   assign idle_timer_slow_out = idle_slow_q;
   assign mode_out            = mode_q;
   assign internal_reset_out  = irst_q;
   assign idle_timer_pend_out = pend_q;

endmodule // pmc_top

// ==== pmc_top_monitor.sv ====
`timescale 1ns/100ps
module pmc_top_monitor (
   input wire       clock_in,
   input wire       rst_in,
   input wire [7:0] reg_addr_in,
   input wire [7:0] reg_wdata_in,
   input wire       reg_wr_in,
   input wire       fast_osc_in,
   input wire       halt_option_in,
   input wire       halt_req_in,
   input wire       idle_req_in,
   input wire       core_active_out,
   input wire       fast_osc_en_out,
   input wire       slow_osc_en_out,
   input wire       idle_timer_slow_out,
   input wire [1:0] mode_out,
   input wire       internal_reset_out
);
   default clocking @(posedge clock_in); endclocking
   default disable iff (rst_in);
   wire [3:0]  nib     = reg_wdata_in[7:4];
   wire [1:0]  osc_on  = reg_wdata_in[7:6];
   wire        idle_sl = reg_wdata_in[5] | reg_wdata_in[4];
   wire [1:0]  mode_ex = {reg_wdata_in[4], reg_wdata_in[5] & ~reg_wdata_in[4]};
   wire        legal   = nib == 4'h4 || nib == 4'hc || nib == 4'he || nib == 4'hf || nib == 4'hb;
   wire        run_ok  = core_active_out && !internal_reset_out;
   wire        ctl_wr  = reg_wr_in && reg_addr_in == 8'h00;
   reg         fast_q;
   reg  [11:0] edges_q;
   // raw pin edges, so the bound absorbs synchroniser and divider phase
   always @(posedge clock_in) begin
      fast_q  <= fast_osc_in;
      edges_q <= internal_reset_out ? edges_q + {11'h000, fast_osc_in & ~fast_q} : 12'h000;
   end
   sequence settled_wr;
      ctl_wr && legal && run_ok && !halt_req_in && (nib != 4'h4 || mode_out == 2'h0)
      ##1 !reg_wr_in && !halt_req_in;
   endsequence
   a_reset_defaults: assert property ($fell(rst_in) |-> fast_osc_en_out && !slow_osc_en_out && mode_out == 2'h0)
      else $error("bad state after reset");
   a_osc_follow: assert property (settled_wr |=> {slow_osc_en_out, fast_osc_en_out} == $past(osc_on, 2))
      else $error("oscillator enables wrong");
   a_idle_clk_sel: assert property (settled_wr |=> idle_timer_slow_out == $past(idle_sl, 2))
      else $error("idle clock select wrong");
   a_mode_follow: assert property (settled_wr |=> $past(nib, 2) == 4'hf || mode_out == $past(mode_ex, 2))
      else $error("mode wrong");
   a_illegal_reset: assert property (ctl_wr && !legal && !internal_reset_out |=> internal_reset_out)
      else $error("illegal code not reset");
   a_irst_length: assert property ($fell(internal_reset_out) |-> edges_q >= 12'h4ab && edges_q <= 12'h50a)
      else $error("internal reset length wrong");
   a_halt_refused: assert property (run_ok && halt_req_in && !halt_option_in && !idle_req_in && !reg_wr_in
      |=> core_active_out)
      else $error("halt taken without option");
   a_halt_stops: assert property (run_ok && halt_req_in && halt_option_in && !reg_wr_in
      |=> !core_active_out ##[0:2] (!fast_osc_en_out && !slow_osc_en_out))
      else $error("halt did not stop");
endmodule // pmc_top_monitor

// ==== tb_top.sv ====
`timescale 1ns/100ps
bind pmc_top pmc_top_monitor mon (.*);
module tb_top;
   logic       clock_in = 1'b0, rst_in = 1'b1, reg_wr_in = 1'b0, reg_rd_in = 1'b0, busy = 1'b0;
   logic       fast_osc_in = 1'b0, slow_osc_in = 1'b0, wakeup_in = 1'b0;
   logic       halt_option_in = 1'b0, halt_req_in = 1'b0, idle_req_in = 1'b0;
   logic [7:0] reg_addr_in = 8'h00, reg_wdata_in = 8'h00, m = 8'h40;
   logic [3:0] path [9] = '{4'hc, 4'he, 4'hf, 4'hb, 4'h4, 4'hf, 4'he, 4'hc, 4'h4};
   logic [3:0] bad [3] = '{4'h1, 4'h5, 4'h8};
   wire  [7:0] reg_rdata_out;
   wire  [1:0] mode_out;
   wire        core_active_out, fast_osc_en_out, slow_osc_en_out, idle_timer_slow_out, internal_reset_out;
   integer     fail_count = 0, checks = 0, cyc = 0, n;

   pmc_top uut (.*, .core_clock_out(), .idle_timer_pend_out());

   always #10 clock_in = ~clock_in;
   // oscillators stand still while disabled, as real pins would
   always #40 fast_osc_in = fast_osc_en_out & ~fast_osc_in;
   // slow pins act only as oscillator inputs here, no wake-up or serial clock use
   always #7010 slow_osc_in = slow_osc_en_out & ~slow_osc_in;
   always @(posedge clock_in) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         fail_count = fail_count + 1;
         give_verdict;
      end
   end

   task chk(input logic [7:0] got, input logic [7:0] exp);
      checks = checks + 1;
      if (got !== exp) begin
         fail_count = fail_count + 1;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock_in);
      reg_addr_in  <= a;
      reg_wdata_in <= d;
      reg_wr_in    <= 1'b1;
      @(posedge clock_in);
      reg_wr_in    <= 1'b0;
      if (a != 8'h00 || busy) return;
      if (!(d[7:4] inside {4'h4, 4'hc, 4'he, 4'hf, 4'hb})) begin
         m    = 8'h40;
         busy = 1'b1;
      end else begin
         if (d[7:4] != 4'h4 || m[7:4] != 4'hb) m[7:4] = d[7:4];
         m[2:0] = d[2:0];
      end
   endtask

   task rd_chk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clock_in);
      reg_addr_in <= a;
      reg_rd_in   <= 1'b1;
      @(posedge clock_in);
      reg_rd_in   <= 1'b0;
      #1 chk(reg_rdata_out, exp);
   endtask

   task step(input logic [3:0] nib);
      logic [7:0] e;
      wr_reg(8'h00, {nib, 1'b0, 3'($urandom)});
      rd_chk(8'h00, m);
      // core on the slow clock reads as low speed, transition code included
      e = {m[7:6], m[5] | m[4], 3'h0, m[4] ? 2'h2 : {1'b0, m[5]}};
      chk({slow_osc_en_out, fast_osc_en_out, idle_timer_slow_out, 3'h0, mode_out}, e);
   endtask

   task req(input logic h, input logic i);
      @(posedge clock_in);
      halt_req_in <= h;
      idle_req_in <= i;
      @(posedge clock_in);
      halt_req_in <= 1'b0;
      idle_req_in <= 1'b0;
      repeat (4) @(negedge clock_in);
   endtask

   task wake_up;
      @(posedge clock_in);
      wakeup_in <= 1'b1;
      n = 0;
      while (core_active_out !== 1'b1 && n < 8000) begin
         @(negedge clock_in);
         n++;
      end
      @(posedge clock_in);
      wakeup_in <= 1'b0;
   endtask

   task give_verdict;
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   initial begin
      void'($urandom(20329));
      repeat (20) @(posedge clock_in);
      rst_in <= 1'b0;
      rd_chk(8'h00, 8'h40);
      wr_reg(8'h07, 8'h5b);
      rd_chk(8'h07, 8'h00);
      rd_chk(8'h00, 8'h40);
      $display("reset and map test done");
      // path starts each oscillator first and leaves dual clock in two writes
      foreach (path[i]) step(path[i]);
      $display("mode path test done");
      foreach (bad[i]) begin
         wr_reg(8'h00, {bad[i], 4'h3});
         wr_reg(8'h00, 8'he0);
         chk({7'h0, internal_reset_out}, 8'h01);
         n = 0;
         while (internal_reset_out !== 1'b0 && n < 8000) begin
            @(negedge clock_in);
            n++;
         end
         chk({7'h0, n >= 4700 && n <= 5400}, 8'h01);
         busy = 1'b0;
         rd_chk(8'h00, m);
      end
      $display("illegal code test done");
      req(1'b1, 1'b0);
      chk({7'h0, core_active_out}, 8'h01);
      @(posedge clock_in);
      halt_option_in <= 1'b1;
      req(1'b1, 1'b0);
      chk({5'h0, core_active_out, fast_osc_en_out, slow_osc_en_out}, 8'h00);
      wake_up;
      chk({7'h0, n >= 5000 && n <= 5400}, 8'h01);
      req(1'b0, 1'b1);
      chk({6'h0, core_active_out, fast_osc_en_out}, 8'h01);
      rd_chk(8'h00, m);
      wake_up;
      chk({7'h0, n < 20}, 8'h01);
      $display("power save test done");
      give_verdict;
   end
endmodule // tb_top
